// ---- arpc_defines.svh ----
`ifndef ARPC_DEFINES_SVH
`define ARPC_DEFINES_SVH
// Overview of operation
// - 18-bit RAM, parity on write, checked on read
// - Read parity mismatch sets status bit 15
// - Bit 16 set writes words without parity
// - Bad map entry withholds slave sync, reports
// - Map error on buffered path empties buffer
// - Bad buffered read data: no delivery, report
// - Block write word error reports, empties buffer
// - Bad vector returns zero, read status, ack
// - Bad register read returns zero, ack, report
`define ARPC_RAM_WIDTH   18
`define ARPC_DATA_WIDTH  16
`define ARPC_ADDR_WIDTH  8
`define ARPC_RAM_DEPTH   256
`define ARPC_CSR_WIDTH   32
`define ARPC_CSR_PERR    15
`define ARPC_CSR_PGDIS   16
`define ARPC_ZERO_DATA   16'h0000
`define ARPC_BYTE_WIDTH  8
`define ARPC_BYTES       2
`define ARPC_PAR_LO      16
`define ARPC_PAR_HI      17
`define ARPC_PAR_NONE    2'h0
`endif

// ---- arpc_pkg.sv ----
package arpc_pkg;
	typedef enum logic [2:0] {
		ARPC_SRC_MAP_UB  = 3'h0,
		ARPC_SRC_MAP_BUF = 3'h1,
		ARPC_SRC_BUF_RD  = 3'h2,
		ARPC_SRC_BLK_WR  = 3'h3,
		ARPC_SRC_VECTOR  = 3'h4,
		ARPC_SRC_REG     = 3'h5
	} arpc_src_type;
	typedef enum logic [1:0] {
		ARPC_IDLE = 2'h0,
		ARPC_WAIT = 2'h1,
		ARPC_DONE = 2'h2
	} arpc_state_type;
endpackage : arpc_pkg

// ---- arpc_ram_if.sv ----
`timescale 1ns/1ps
`include "arpc_defines.svh"
interface arpc_ram_if;
	logic                         wr_en;
	logic [`ARPC_ADDR_WIDTH-1:0]  wr_addr;
	logic [`ARPC_RAM_WIDTH-1:0]   wr_data;
	logic                         rd_en;
	logic [`ARPC_ADDR_WIDTH-1:0]  rd_addr;
	logic [`ARPC_RAM_WIDTH-1:0]   rd_data;
	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface : arpc_ram_if

// ---- arpc_ram.sv ----
`timescale 1ns/1ps
`include "arpc_defines.svh"
module arpc_ram (
	input wire logic clock_i,
	arpc_ram_if.mem  port
);
	logic [`ARPC_RAM_WIDTH-1:0] store [`ARPC_RAM_DEPTH];
	logic [`ARPC_RAM_WIDTH-1:0] rd_q;
	always_ff @(posedge clock_i) begin
		if (port.wr_en) begin
			store[port.wr_addr] <= port.wr_data;
		end
		if (port.rd_en) begin
			rd_q <= store[port.rd_addr];
		end
	end
	assign port.rd_data = rd_q;
endmodule : arpc_ram

// ---- adapter_ram_parity_checker.sv ----
`timescale 1ns/1ps
`include "arpc_defines.svh"
module adapter_ram_parity_checker
	import arpc_pkg::*;
(
	// Clock and reset
	input  wire logic                        clock_i,
	input  wire logic                        srst_i,
	// Control and status
	input  wire logic                        pgen_disable_i,
	input  wire logic                        perr_clear_i,
	output logic      [`ARPC_CSR_WIDTH-1:0]  csr_o,
	// RAM write request
	input  wire logic                        wr_req_i,
	input  wire logic [`ARPC_ADDR_WIDTH-1:0] wr_addr_i,
	input  wire logic [`ARPC_DATA_WIDTH-1:0] wr_data_i,
	// RAM read request
	input  wire logic                        rd_req_i,
	input  wire logic [`ARPC_ADDR_WIDTH-1:0] rd_addr_i,
	input  wire arpc_src_type                rd_src_i,
	// Read answer
	output logic                             rd_valid_o,
	output logic      [`ARPC_DATA_WIDTH-1:0] rd_data_o,
	output logic                             rd_perr_o,
	// Transfer effects
	output logic                             slave_sync_response_o,
	output logic                             xfer_abort_o,
	output logic                             buffered_path_empty_o,
	output logic                             sysbus_ack_o,
	output logic                             sysbus_perr_report_o
);
	// ------------------------------------------------------------
	// State and decode types
	// ------------------------------------------------------------
	typedef struct packed {
		arpc_state_type               state;
		arpc_src_type                 src;
		logic                         perr;
		logic                         valid;
		logic [`ARPC_DATA_WIDTH-1:0]  data;
		logic                         rperr;
		logic                         ssr;
		logic                         abort;
		logic                         bp_empty;
		logic                         ack;
		logic                         report;
		logic                         pgdis;
	} arpc_regs_type;

	typedef struct packed {
		logic sync_on_good;
		logic ack_on_any;
		logic abort_on_err;
		logic empty_on_err;
	} arpc_effect_type;

	arpc_regs_type              r;
	arpc_regs_type              next_r;
	arpc_effect_type            eff;
	arpc_ram_if                 ram ();
	logic                       take;
	logic                       bad;
	logic [`ARPC_RAM_WIDTH-1:0] word;
	logic [`ARPC_BYTES-1:0]     gen_par;
	logic [`ARPC_BYTES-1:0]     chk_ok;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	arpc_ram u_ram (
		.clock_i (clock_i),
		.port    (ram.mem)
	);

	// ------------------------------------------------------------
	// Parity generation and check, one bit per byte
	// ------------------------------------------------------------
	for (genvar b = 0; b < `ARPC_BYTES; b++) begin : g_byte
		assign gen_par[b] = ~^wr_data_i[b*`ARPC_BYTE_WIDTH +: `ARPC_BYTE_WIDTH];
		assign chk_ok[b]  = ^{word[`ARPC_PAR_LO+b], word[b*`ARPC_BYTE_WIDTH +: `ARPC_BYTE_WIDTH]};
	end

	// ------------------------------------------------------------
	// Read acceptance
	// ------------------------------------------------------------
	assign take        = rd_req_i && (r.state == ARPC_IDLE);

	// ------------------------------------------------------------
	// RAM access
	// ------------------------------------------------------------
	assign ram.wr_en   = wr_req_i;
	assign ram.wr_addr = wr_addr_i;
	assign ram.wr_data = pgen_disable_i ? {`ARPC_PAR_NONE, wr_data_i} :
		{gen_par, wr_data_i};
	assign ram.rd_en   = take;
	assign ram.rd_addr = rd_addr_i;
	assign word        = ram.rd_data;
	// Both parity bits clear always counts as bad, so disabled writes are caught
	assign bad         = (word[`ARPC_PAR_HI:`ARPC_PAR_LO] == `ARPC_PAR_NONE) || !(&chk_ok);

	// ------------------------------------------------------------
	// Effect of each read source
	// ------------------------------------------------------------
	always_comb begin
		eff = '0;
		case (r.src)
			ARPC_SRC_MAP_UB: begin
				eff.sync_on_good = 1'b1;
				eff.ack_on_any   = 1'b0;
				eff.abort_on_err = 1'b1;
				eff.empty_on_err = 1'b0;
			end
			ARPC_SRC_MAP_BUF: begin
				eff.sync_on_good = 1'b0;
				eff.ack_on_any   = 1'b0;
				eff.abort_on_err = 1'b0;
				eff.empty_on_err = 1'b1;
			end
			ARPC_SRC_BUF_RD: begin
				eff.sync_on_good = 1'b1;
				eff.ack_on_any   = 1'b0;
				eff.abort_on_err = 1'b1;
				eff.empty_on_err = 1'b0;
			end
			ARPC_SRC_BLK_WR: begin
				eff.sync_on_good = 1'b0;
				eff.ack_on_any   = 1'b0;
				eff.abort_on_err = 1'b1;
				eff.empty_on_err = 1'b1;
			end
			ARPC_SRC_VECTOR: begin
				eff.sync_on_good = 1'b0;
				eff.ack_on_any   = 1'b1;
				eff.abort_on_err = 1'b0;
				eff.empty_on_err = 1'b0;
			end
			ARPC_SRC_REG: begin
				eff.sync_on_good = 1'b0;
				eff.ack_on_any   = 1'b1;
				eff.abort_on_err = 1'b0;
				eff.empty_on_err = 1'b0;
			end
			default: begin
				eff.sync_on_good = 1'b0;
				eff.ack_on_any   = 1'b0;
				eff.abort_on_err = 1'b1;
				eff.empty_on_err = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Check and react
	// ------------------------------------------------------------
	always_comb begin
		next_r          = r;
		next_r.valid    = 1'b0;
		next_r.rperr    = 1'b0;
		next_r.ssr      = 1'b0;
		next_r.abort    = 1'b0;
		next_r.bp_empty = 1'b0;
		next_r.ack      = 1'b0;
		next_r.report   = 1'b0;
		next_r.pgdis    = pgen_disable_i;
		// Sticky flag: a set later in this process wins over the clear
		if (perr_clear_i) begin
			next_r.perr = 1'b0;
		end
		case (r.state)
			ARPC_IDLE: begin
				if (take) begin
					next_r.src   = rd_src_i;
					next_r.state = ARPC_WAIT;
				end
			end
			ARPC_WAIT: begin
				next_r.state = ARPC_IDLE;
				next_r.valid = 1'b1;
				next_r.rperr = bad;
				next_r.data  = word[`ARPC_DATA_WIDTH-1:0];
				if (!bad) begin
					next_r.ssr = eff.sync_on_good;
					next_r.ack = eff.ack_on_any;
				end else begin
					next_r.perr     = 1'b1;
					next_r.report   = 1'b1;
					next_r.data     = `ARPC_ZERO_DATA;
					next_r.abort    = eff.abort_on_err;
					next_r.bp_empty = eff.empty_on_err;
					next_r.ack      = eff.ack_on_any;
				end
			end
			default: next_r.state = ARPC_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	always_comb begin
		csr_o                  = '0;
		csr_o[`ARPC_CSR_PERR]  = r.perr;
		csr_o[`ARPC_CSR_PGDIS] = r.pgdis;
	end

	// ------------------------------------------------------------
	// Read answer and effects
	// ------------------------------------------------------------
	assign rd_valid_o            = r.valid;
	assign rd_data_o             = r.data;
	assign rd_perr_o             = r.rperr;
	assign slave_sync_response_o = r.ssr;
	assign xfer_abort_o          = r.abort;
	assign buffered_path_empty_o = r.bp_empty;
	assign sysbus_ack_o          = r.ack;
	assign sysbus_perr_report_o  = r.report;
endmodule : adapter_ram_parity_checker

// ---- arpc_sva.sv ----
`timescale 1ns/1ps
module arpc_sva (
	// Watched ports
	input wire logic        clock_i,
	input wire logic        srst_i,
	input wire logic        pgen_disable_i,
	input wire logic        rd_req_i,
	input wire logic [31:0] csr_o,
	input wire logic        rd_valid_o,
	input wire logic [15:0] rd_data_o,
	input wire logic        rd_perr_o,
	input wire logic        slave_sync_response_o,
	input wire logic        xfer_abort_o,
	input wire logic        buffered_path_empty_o,
	input wire logic        sysbus_ack_o,
	input wire logic        sysbus_perr_report_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);
	// Read taken on the previous edge
	logic tk_q;
	always_ff @(posedge clock_i) begin
		tk_q <= !srst_i && rd_req_i && !tk_q;
	end
	a_read_answered: assert property (rd_req_i && !tk_q |-> ##2 rd_valid_o) else $error("read not answered");
	a_answer_caused: assert property (rd_valid_o |-> $past(rd_req_i, 2)) else $error("answer without read");
	a_perr_sets_csr: assert property (rd_perr_o |-> csr_o[15]) else $error("status bit 15 not set");
	a_pgdis_csr: assert property (!$past(srst_i) |-> csr_o[16] == $past(pgen_disable_i)) else $error("bit 16 wrong");
	a_sync_withheld: assert property (rd_perr_o |-> !slave_sync_response_o) else $error("sync on error");
	a_error_reported: assert property (rd_perr_o |-> sysbus_perr_report_o) else $error("error not reported");
	a_empty_on_err: assert property (buffered_path_empty_o |-> rd_perr_o) else $error("empty without error");
	a_abort_on_err: assert property (xfer_abort_o |-> rd_perr_o) else $error("abort without error");
	a_zero_on_err: assert property (rd_perr_o |-> rd_data_o == 16'h0000) else $error("data not zero");
	a_ack_answer: assert property (sysbus_ack_o |-> rd_valid_o) else $error("ack without answer");
endmodule : arpc_sva
bind adapter_ram_parity_checker arpc_sva chk_u (.clock_i, .srst_i, .pgen_disable_i, .rd_req_i, .csr_o, .rd_valid_o,
	.rd_data_o, .rd_perr_o, .slave_sync_response_o, .xfer_abort_o, .buffered_path_empty_o, .sysbus_ack_o,
	.sysbus_perr_report_o);

// ---- arpc_master.sv ----
`timescale 1ns/1ps
module arpc_master (
	// Answer from adapter
	input  wire logic        sysbus_ack_i,
	input  wire logic [15:0] rd_data_i,
	// Verdict
	output logic             vec_fail_o
);
	// Zero data answer taken as failure
	assign vec_fail_o = sysbus_ack_i && (rd_data_i == 16'h0000);
endmodule : arpc_master

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import arpc_pkg::*;
	logic         clock_i = 0, srst_i = 1, pgen_disable_i = 0, perr_clear_i = 0;
	logic         wr_req_i = 0, rd_req_i = 0, rd_valid_o, rd_perr_o, slave_sync_response_o, xfer_abort_o;
	logic         buffered_path_empty_o, sysbus_ack_o, sysbus_perr_report_o, vec_fail;
	logic [7:0]   wr_addr_i = 8'h00, rd_addr_i = 8'h00;
	logic [15:0]  wr_data_i = 16'h0000, rd_data_o;
	logic [31:0]  csr_o;
	arpc_src_type rd_src_i = ARPC_SRC_REG;
	int           fail_count = 0, check_count = 0, cyc = 0;
	adapter_ram_parity_checker dut_u (.clock_i, .srst_i, .pgen_disable_i, .perr_clear_i, .csr_o, .wr_req_i, .wr_addr_i,
		.wr_data_i, .rd_req_i, .rd_addr_i, .rd_src_i, .rd_valid_o, .rd_data_o, .rd_perr_o, .slave_sync_response_o,
		.xfer_abort_o, .buffered_path_empty_o, .sysbus_ack_o, .sysbus_perr_report_o);
	arpc_master mst_u (.sysbus_ack_i(sysbus_ack_o), .rd_data_i(rd_data_o), .vec_fail_o(vec_fail));
	always #5 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 2000) begin
			fail_count++;
			close_out();
		end
	end
	// ----------------
	// Helpers
	// ----------------
	task close_out();
		$display("fail_count=%0d check_count=%0d", fail_count, check_count);
		if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	task chk(input logic c);
		check_count++;
		if (c !== 1'b1) begin
			fail_count++;
			$display("unexpected at %0t: mismatch", $time);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock_i) {wr_req_i, wr_addr_i, wr_data_i} <= {1'b1, a, d};
		@(posedge clock_i) wr_req_i <= 1'b0;
	endtask : wr
	task rd(input arpc_src_type s, input logic [7:0] a);
		@(posedge clock_i) {rd_req_i, rd_addr_i, rd_src_i} <= {1'b1, a, s};
		@(posedge clock_i) rd_req_i <= 1'b0;
		@(posedge clock_i);
		#1;
	endtask : rd
	// ----------------
	// Scenarios
	// ----------------
	task t_good();
		wr(8'h05, 16'h1234);
		rd(ARPC_SRC_REG, 8'h05);
		chk(rd_valid_o === 1'b1 && rd_data_o === 16'h1234 && rd_perr_o === 1'b0 && sysbus_ack_o === 1'b1);
		rd(ARPC_SRC_MAP_UB, 8'h05);
		chk(slave_sync_response_o === 1'b1 && xfer_abort_o === 1'b0 && csr_o[15] === 1'b0);
		wr(8'h06, 16'h0000);
		rd(ARPC_SRC_REG, 8'h06);
		chk(rd_valid_o === 1'b1 && rd_perr_o === 1'b0 && sysbus_perr_report_o === 1'b0);
	endtask : t_good
	task t_bad();
		@(posedge clock_i) pgen_disable_i <= 1'b1;
		wr(8'h0a, 16'h5555);
		#1;
		chk(csr_o[16] === 1'b1);
		@(posedge clock_i) pgen_disable_i <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(arpc_src_type'(i[2:0]), 8'h0a);
			chk(rd_perr_o === 1'b1 && sysbus_perr_report_o === 1'b1 && rd_data_o === 16'h0000);
			chk(slave_sync_response_o === 1'b0 && csr_o[15] === 1'b1);
			chk(xfer_abort_o === (i == 0 || i == 2 || i == 3));
			chk(buffered_path_empty_o === (i == 1 || i == 3));
			chk(sysbus_ack_o === (i >= 4) && vec_fail === (i >= 4));
		end
	endtask : t_bad
	task t_clear();
		@(posedge clock_i) perr_clear_i <= 1'b1;
		@(posedge clock_i) perr_clear_i <= 1'b0;
		@(posedge clock_i) #1;
		chk(csr_o[15] === 1'b0 && csr_o[16] === 1'b0);
	endtask : t_clear
	initial begin
		repeat (12) @(posedge clock_i);
		srst_i <= 1'b0;
		t_good();
		t_bad();
		t_clear();
		close_out();
	end
endmodule : tb_top
